// ===== core/scsi_admit_pkg.sv
// constants and types shared by the command admission logic
package scsi_admit_pkg;

  // command classes presented with each command
  localparam logic [2:0] KIND_OTHER      = 3'h0;
  localparam logic [2:0] KIND_INQUIRY    = 3'h1;
  localparam logic [2:0] KIND_REQ_SENSE  = 3'h2;
  localparam logic [2:0] KIND_FORMAT     = 3'h3;
  localparam logic [2:0] KIND_UNIT_START = 3'h4;

  // default sizes
  localparam int DEF_INITIATORS  = 16;
  localparam int DEF_QUEUE_DEPTH = 8;
  localparam int DEF_RESERVE     = 0;
  localparam int DEF_TAG_W       = 8;

  // verdict given for each command received without cmd_bus_error; a dequeue reports through deq_done and deq_blocked
  typedef enum logic [3:0] {
    V_EXECUTE     = 4'h1,
    V_QUEUE       = 4'h2,
    V_QFULL       = 4'h3,
    V_BUSY        = 4'h4,
    V_CHK_LUN     = 4'h5,
    V_CHK_OVERLAP = 4'h6,
    V_CHK_UA      = 4'h7,
    V_CHK_NREADY  = 4'h8,
    V_CHK_DEFER   = 4'h9,
    V_RES_CONFL   = 4'ha,
    V_CHK_OPCODE  = 4'hb,
    V_CHK_CDB     = 4'hc,
    V_SENSE_UA    = 4'hd
  } verdict_e;

endpackage

// ===== core/scsi_target_command_admission.sv
// command admission, queue slot tracking and unit attention for one logical unit
`timescale 1ns/10ps
module scsi_target_command_admission
  import scsi_admit_pkg::*;
#(
  parameter int N_INIT  = DEF_INITIATORS,
  parameter int DEPTH   = DEF_QUEUE_DEPTH,
  parameter int RESERVE = DEF_RESERVE,
  parameter int TAG_W   = DEF_TAG_W,
  parameter int IW      = $clog2(N_INIT),
  parameter int SW      = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // command arrival, one-cycle strobe with its qualifiers
  input  wire logic              cmd_valid,
  input  wire logic [IW-1:0]     cmd_init,
  input  wire logic              cmd_tagged,
  input  wire logic [TAG_W-1:0]  cmd_tag,
  input  wire logic [2:0]        cmd_kind,
  input  wire logic              cmd_lun_ok,
  input  wire logic              cmd_disc_ok,
  input  wire logic              cmd_linked,
  input  wire logic              cmd_concurrent_ok,
  input  wire logic              cmd_bus_error,
  // target conditions
  input  wire logic              startup_format_active,
  input  wire logic              deferred_error,
  input  wire logic              reservation_conflict,
  input  wire logic              opcode_invalid,
  input  wire logic              cdb_invalid,
  input  wire logic              tagged_queue_disable,
  input  wire logic              queue_error_policy,
  // sense built elsewhere
  input  wire logic              sense_set,
  input  wire logic [IW-1:0]     sense_set_init,
  // process life cycle
  input  wire logic              deq_valid,
  input  wire logic [SW-1:0]     deq_slot,
  input  wire logic              done_valid,
  input  wire logic [SW-1:0]     done_slot,
  // attention events
  input  wire logic              ua_reset_evt,
  input  wire logic              ua_xcvr_evt,
  input  wire logic              ua_threshold_evt,
  input  wire logic              ua_param_evt,
  input  wire logic              ua_ucode_evt,
  input  wire logic [IW-1:0]     ua_src_init,
  input  wire logic              ua_preempt_evt,
  input  wire logic [IW-1:0]     ua_victim_init,
  input  wire logic              clear_queue_evt,
  input  wire logic              ca_clear_evt,
  // verdict
  output logic                   resp_valid,
  output verdict_e               resp_code,
  output logic [IW-1:0]          resp_init,
  output logic [SW-1:0]          resp_slot,
  output logic                   term_valid,
  output logic                   deq_done,
  output logic                   deq_blocked,
  // per-initiator state
  output logic [N_INIT-1:0]      ua_pending,
  output logic [N_INIT-1:0]      sense_pending
);

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [DEPTH-1:0]              slot_valid, next_slot_valid;
  logic [DEPTH-1:0]              slot_active, next_slot_active;
  logic [DEPTH-1:0]              slot_tagged, next_slot_tagged;
  logic [DEPTH-1:0]              slot_fs, next_slot_fs;
  logic [IW-1:0]                 slot_init [DEPTH];
  logic [IW-1:0]                 next_slot_init [DEPTH];
  logic [TAG_W-1:0]              slot_tag [DEPTH];
  logic [TAG_W-1:0]              next_slot_tag [DEPTH];
  logic [N_INIT-1:0]             ua_reported, next_ua_reported;
  logic [N_INIT-1:0]             ua_more, next_ua_more;
  logic [N_INIT-1:0]             next_ua_pending, next_sense_pending;
  logic                          tqd_q, next_tqd_q;
  logic                          next_resp_valid, next_term_valid;
  verdict_e                      next_resp_code;
  logic [IW-1:0]                 next_resp_init;
  logic [SW-1:0]                 next_resp_slot;
  logic                          next_deq_done, next_deq_blocked;

  // survey of the slot table
  logic                          own_any, own_untag, own_tag_hit, any_active, fs_wait, found;
  logic [SW:0]                   own_count, free_count;
  logic [SW-1:0]                 free_idx;
  logic [N_INIT-1:0]             q_mask, ua_set, kill_mask, src_bit;
  logic                          is_ir, overlap, base_q, try_q, qfull_c, busy_c, ua_hit, exec_ok;
  logic                          accept;

  localparam logic [SW:0] RES_OTHERS = (SW+1)'(RESERVE * (N_INIT - 1));
  localparam logic [SW:0] RES_OWN    = (SW+1)'(RESERVE);

  //////////////////////////////////////////////////////////////////////////////
  // slot survey: everything the admission decision needs about one initiator
  always_comb begin
    {own_any, own_untag, own_tag_hit, any_active, fs_wait, found} = '0;
    {own_count, free_count, free_idx, q_mask}                     = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (slot_valid[i]) begin
        if (slot_init[i] == cmd_init) begin
          own_any   = 1'b1;
          own_count = own_count + 1'b1;
          if (!slot_tagged[i]) own_untag = 1'b1;
          else if (slot_tag[i] == cmd_tag) own_tag_hit = 1'b1;
        end
        if (slot_active[i]) any_active = 1'b1;
        else begin
          fs_wait = fs_wait | slot_fs[i];
          q_mask[slot_init[i]] = 1'b1;
        end
      end else begin
        free_count = free_count + 1'b1;
        if (!found) begin
          found    = 1'b1;
          free_idx = SW'(i);
        end
      end
    end
  end

  // admission terms; queue checks only matter with a process already active
  assign is_ir   = (cmd_kind == KIND_INQUIRY) || (cmd_kind == KIND_REQ_SENSE);
  assign overlap = cmd_tagged ? (own_untag || own_tag_hit)
                 : (own_any && !(cmd_kind == KIND_REQ_SENSE && sense_pending[cmd_init]));
  assign base_q  = !cmd_linked && (cmd_tagged ? (!tagged_queue_disable && own_any && !own_tag_hit)
                                              : !own_untag);
  assign try_q   = any_active && !is_ir && !startup_format_active && !cmd_concurrent_ok && base_q;
  assign qfull_c = (try_q && cmd_disc_ok && (free_count == '0 ||
                    (own_count >= RES_OWN && free_count <= RES_OTHERS)))
                 || (any_active && fs_wait && !tagged_queue_disable);
  assign busy_c  = (any_active && fs_wait && tagged_queue_disable)
                 || (try_q && !cmd_disc_ok);
  assign ua_hit  = ua_pending[cmd_init] && !ua_reported[cmd_init] && cmd_kind != KIND_INQUIRY;
  assign exec_ok = !any_active || is_ir || cmd_concurrent_ok;
  assign accept  = cmd_valid && !cmd_bus_error;
  assign src_bit = N_INIT'(1) << ua_src_init;

  //////////////////////////////////////////////////////////////////////////////
  // next state: attention, sense, slot table and verdict
  always_comb begin
    next_slot_valid    = slot_valid;
    next_slot_active   = slot_active;
    next_slot_tagged   = slot_tagged;
    next_slot_fs       = slot_fs;
    next_slot_init     = slot_init;
    next_slot_tag      = slot_tag;
    next_ua_pending    = ua_pending;
    next_ua_reported   = ua_reported;
    next_ua_more       = ua_more;
    next_sense_pending = sense_pending;
    next_tqd_q         = tagged_queue_disable;
    next_resp_code     = resp_code;
    next_resp_init     = resp_init;
    next_resp_slot     = resp_slot;
    {next_resp_valid, next_term_valid, next_deq_done, next_deq_blocked} = '0;
    {ua_set, kill_mask} = '0;
    // attention sources
    if (ua_reset_evt || ua_xcvr_evt || ua_threshold_evt) ua_set = '1;
    if (ua_param_evt || ua_ucode_evt) ua_set = ua_set | ~src_bit;
    if (ua_preempt_evt) ua_set[ua_victim_init] = 1'b1;
    if (clear_queue_evt || (ca_clear_evt && queue_error_policy)) kill_mask = q_mask & ~src_bit;
    if (tagged_queue_disable && !tqd_q) kill_mask = kill_mask | q_mask;
    ua_set = ua_set | kill_mask;
    // cleared queues lose their waiting entries
    for (int i = 0; i < DEPTH; i++) begin
      if (slot_valid[i] && !slot_active[i] && kill_mask[slot_init[i]]) next_slot_valid[i] = 1'b0;
    end
    // completion frees the slot
    if (done_valid) next_slot_valid[done_slot] = 1'b0;
    // dequeue re-checks what could have changed while waiting
    if (deq_valid && slot_valid[deq_slot] && !slot_active[deq_slot]) begin
      next_deq_done = 1'b1;
      if (startup_format_active || deferred_error || reservation_conflict ||
          (ua_pending[slot_init[deq_slot]] && !ua_reported[slot_init[deq_slot]])) begin
        next_deq_blocked          = 1'b1;
        next_slot_valid[deq_slot] = 1'b0;
      end else begin
        next_slot_active[deq_slot] = 1'b1;
      end
    end
    // command admission, highest priority first
    if (accept) begin
      next_resp_valid = 1'b1;
      next_resp_init  = cmd_init;
      next_resp_slot  = free_idx;
      if (!is_ir) next_sense_pending[cmd_init] = 1'b0;
      if (!cmd_lun_ok) begin
        next_resp_code = V_CHK_LUN;
      end else if (overlap) begin
        next_resp_code  = V_CHK_OVERLAP;
        next_term_valid = 1'b1;
        for (int i = 0; i < DEPTH; i++) begin
          if (slot_init[i] == cmd_init) next_slot_valid[i] = 1'b0;
        end
      end else if (qfull_c) begin
        next_resp_code = V_QFULL;
      end else if (busy_c) begin
        next_resp_code = V_BUSY;
      end else if (ua_hit) begin
        if (cmd_kind != KIND_REQ_SENSE) begin
          next_resp_code                = V_CHK_UA;
          next_ua_reported[cmd_init]    = 1'b1;
        end else if (sense_pending[cmd_init]) begin
          next_resp_code = V_EXECUTE;
        end else begin
          next_resp_code                = V_SENSE_UA;
          next_ua_pending[cmd_init]     = 1'b0;
          next_ua_more[cmd_init]        = 1'b0;
        end
      end else if (ua_pending[cmd_init] && ua_reported[cmd_init] &&
                   cmd_kind == KIND_REQ_SENSE) begin
        next_resp_code              = V_SENSE_UA;
        next_ua_pending[cmd_init]   = ua_more[cmd_init];
        next_ua_reported[cmd_init]  = 1'b0;
        next_ua_more[cmd_init]      = 1'b0;
      end else if (startup_format_active && !is_ir) begin
        next_resp_code = V_CHK_NREADY;
      end else if (deferred_error) begin
        next_resp_code = V_CHK_DEFER;
      end else if (reservation_conflict) begin
        next_resp_code = V_RES_CONFL;
      end else if (opcode_invalid) begin
        next_resp_code = V_CHK_OPCODE;
      end else if (cdb_invalid) begin
        next_resp_code = V_CHK_CDB;
      end else if (exec_ok || (base_q && cmd_disc_ok && found)) begin
        // executed or queued; a reported attention is now spent unless the command is an inquiry
        if (ua_reported[cmd_init] && cmd_kind != KIND_INQUIRY) begin
          next_ua_pending[cmd_init]  = ua_more[cmd_init];
          next_ua_reported[cmd_init] = 1'b0;
          next_ua_more[cmd_init]     = 1'b0;
        end
        next_resp_code = exec_ok ? V_EXECUTE : V_QUEUE;
        // inquiry and request sense run beside the queue and take no slot
        if (found && !(exec_ok && is_ir)) begin
          next_slot_valid[free_idx]  = 1'b1;
          next_slot_active[free_idx] = exec_ok;
          next_slot_tagged[free_idx] = cmd_tagged;
          next_slot_tag[free_idx]    = cmd_tag;
          next_slot_init[free_idx]   = cmd_init;
          next_slot_fs[free_idx]     = cmd_kind == KIND_FORMAT || cmd_kind == KIND_UNIT_START;
        end
      end else begin
        next_resp_code = V_BUSY;  // not queueable: nothing better to offer
      end
      // every check condition leaves sense for the initiator
      if (next_resp_code inside {V_CHK_LUN, V_CHK_OVERLAP, V_CHK_UA, V_CHK_NREADY,
                                 V_CHK_DEFER, V_CHK_OPCODE, V_CHK_CDB})
        next_sense_pending[cmd_init] = 1'b1;
    end
    // new events win over clears in the same cycle
    if (sense_set) next_sense_pending[sense_set_init] = 1'b1;
    next_ua_more     = next_ua_more | (ua_set & next_ua_pending);
    next_ua_reported = next_ua_reported & ~(ua_set & ~next_ua_pending);
    next_ua_pending  = next_ua_pending | ua_set;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers; power-on reset leaves attention pending for everyone
  always_ff @(posedge clk) begin
    if (reset) begin
      {slot_valid, slot_active, slot_tagged, slot_fs} <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        slot_init[i] <= '0;
        slot_tag[i]  <= '0;
      end
      ua_pending    <= '1;
      {ua_reported, ua_more, sense_pending, tqd_q} <= '0;
      {resp_valid, term_valid, deq_done, deq_blocked} <= '0;
      resp_code     <= V_EXECUTE;
      {resp_init, resp_slot} <= '0;
    end else begin
      slot_valid    <= next_slot_valid;
      slot_active   <= next_slot_active;
      slot_tagged   <= next_slot_tagged;
      slot_fs       <= next_slot_fs;
      slot_init     <= next_slot_init;
      slot_tag      <= next_slot_tag;
      ua_pending    <= next_ua_pending;
      ua_reported   <= next_ua_reported;
      ua_more       <= next_ua_more;
      sense_pending <= next_sense_pending;
      tqd_q         <= next_tqd_q;
      resp_valid    <= next_resp_valid;
      resp_code     <= next_resp_code;
      resp_init     <= next_resp_init;
      resp_slot     <= next_resp_slot;
      term_valid    <= next_term_valid;
      deq_done      <= next_deq_done;
      deq_blocked   <= next_deq_blocked;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_overlap_term: assert property (accept && cmd_lun_ok && overlap |=>
    term_valid && resp_code == V_CHK_OVERLAP) else $error("overlap not reported");
  a_rs_no_overlap: assert property (accept && !cmd_tagged && cmd_kind == KIND_REQ_SENSE &&
    sense_pending[cmd_init] |=> resp_code != V_CHK_OVERLAP) else $error("sense read flagged");
  a_sense_discard: assert property ($past(accept && !is_ir && !sense_set) && resp_valid &&
    resp_code inside {V_EXECUTE, V_QUEUE, V_QFULL, V_BUSY} |-> !sense_pending[resp_init])
    else $error("sense kept");
  a_term_overlap: assert property (term_valid |-> resp_valid &&
    resp_code == V_CHK_OVERLAP && !(|(slot_valid & ~$past(slot_valid)))) else $error("bad term");
  a_idle_exec: assert property (accept && cmd_lun_ok && slot_valid == '0 && !ua_pending[cmd_init] &&
    !startup_format_active && !deferred_error && !reservation_conflict && !opcode_invalid &&
    !cdb_invalid |=> resp_code == V_EXECUTE) else $error("idle command not run");
  a_not_ready: assert property (accept && cmd_lun_ok && !overlap && !qfull_c && !busy_c &&
    !ua_hit && !ua_reported[cmd_init] && startup_format_active && !is_ir |=>
    resp_code == V_CHK_NREADY) else $error("not ready missed");
  a_qfull_code: assert property (accept && cmd_lun_ok && !overlap && qfull_c |=>
    resp_valid && resp_code == V_QFULL) else $error("queue full missed");
  a_busy_format: assert property (accept && cmd_lun_ok && !overlap && any_active && fs_wait &&
    tagged_queue_disable && !qfull_c |=> resp_code == V_BUSY) else $error("busy missed");
  a_ucode_others: assert property (ua_ucode_evt |=>
    &(ua_pending | $past(src_bit))) else $error("ucode attention missing");
  a_ua_held: assert property (ua_pending[0] && !(accept && cmd_init == '0) |=>
    ua_pending[0]) else $error("attention lost");
  a_deq_block: assert property (deq_valid && slot_valid[deq_slot] && !slot_active[deq_slot] &&
    startup_format_active |=> deq_done && deq_blocked) else $error("dequeue not blocked");

  c_queued:   cover property (resp_valid && resp_code == V_QUEUE);
  c_overlap:  cover property (term_valid);
  c_ua_sense: cover property (resp_valid && resp_code == V_SENSE_UA);
  c_deq_run:  cover property (deq_done && !deq_blocked);

endmodule

// ===== tb/scsi_initiator_model.sv
// initiator model: presents one command strobe per call
`timescale 1ns/10ps
module scsi_initiator_model (
  // clock
  input  wire logic clk,
  // command toward the target
  output logic       cmd_valid,
  output logic [3:0] cmd_init,
  output logic       cmd_tagged,
  output logic [7:0] cmd_tag,
  output logic [2:0] cmd_kind,
  output logic       cmd_disc_ok
);
  // idle at time zero
  initial begin
    cmd_valid = 1'b0;
    {cmd_init, cmd_tagged, cmd_tag, cmd_kind, cmd_disc_ok} = '0;
  end

  // strobe lasts one cycle; qualifiers are inverted afterwards so that
  // a design reading stale fields outside the strobe gets caught
  task automatic send(input logic [3:0] ini, input logic [2:0] k,
                      input logic tg, input logic dc);
    @(negedge clk);
    cmd_valid = 1'b1;
    {cmd_init, cmd_kind, cmd_tagged, cmd_disc_ok} = {ini, k, tg, dc};
    cmd_tag = 8'h5a;
    @(negedge clk);
    cmd_valid = 1'b0;
    {cmd_init, cmd_kind, cmd_tagged, cmd_disc_ok} = ~{ini, k, tg, dc};
    cmd_tag = 8'ha5;
  endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the command admission block
`timescale 1ns/10ps
module tb_top
  import scsi_admit_pkg::*;
;
  logic        clk, reset, cmd_valid, cmd_tagged, cmd_disc_ok;
  logic [3:0]  cmd_init, sense_set_init, ua_src_init, ua_victim_init, resp_init;
  logic [7:0]  cmd_tag;
  logic [2:0]  cmd_kind, deq_slot, done_slot, resp_slot, qslot;
  logic        cmd_lun_ok, cmd_linked, cmd_concurrent_ok, cmd_bus_error;
  logic        startup_format_active, deferred_error, reservation_conflict;
  logic        opcode_invalid, cdb_invalid, tagged_queue_disable, queue_error_policy;
  logic        sense_set, deq_valid, done_valid, ua_reset_evt, ua_xcvr_evt;
  logic        ua_threshold_evt, ua_param_evt, ua_ucode_evt, ua_preempt_evt;
  logic        clear_queue_evt, ca_clear_evt, resp_valid, term_valid;
  logic        deq_done, deq_blocked;
  logic [15:0] ua_pending, sense_pending;
  verdict_e    resp_code;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  ////////////////////////////////////////////////////////////////////////
  scsi_initiator_model i_scsi_initiator_model (
    .clk, .cmd_valid, .cmd_init, .cmd_tagged, .cmd_tag, .cmd_kind, .cmd_disc_ok
  );
  scsi_target_command_admission i_scsi_target_command_admission (
    .clk, .reset, .cmd_valid, .cmd_init, .cmd_tagged, .cmd_tag, .cmd_kind,
    .cmd_lun_ok, .cmd_disc_ok, .cmd_linked, .cmd_concurrent_ok, .cmd_bus_error,
    .startup_format_active, .deferred_error, .reservation_conflict,
    .opcode_invalid, .cdb_invalid, .tagged_queue_disable, .queue_error_policy,
    .sense_set, .sense_set_init, .deq_valid, .deq_slot, .done_valid, .done_slot,
    .ua_reset_evt, .ua_xcvr_evt, .ua_threshold_evt, .ua_param_evt, .ua_ucode_evt,
    .ua_src_init, .ua_preempt_evt, .ua_victim_init, .clear_queue_evt,
    .ca_clear_evt, .resp_valid, .resp_code, .resp_init, .resp_slot, .term_valid,
    .deq_done, .deq_blocked, .ua_pending, .sense_pending
  );

  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard; the sequence needs about 60 cycles
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      test_done();
    end
  end

  // one compare task per kind of result
  task automatic chk_code(input verdict_e got, input verdict_e exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_num(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // the verdict is registered and resp_valid stands one cycle only, so it is
  // sampled at the falling edge right after the edge that took the strobe
  task automatic cmd(input logic [3:0] ini, input logic [2:0] k, input logic tg,
                     input logic dc, input verdict_e exp);
    i_scsi_initiator_model.send(ini, k, tg, dc);
    chk_bit(resp_valid, 1'b1);
    chk_code(resp_code, exp);
    chk_num(resp_init, ini);
  endtask

  // report the attention, then collect it with request sense
  task automatic ua_clear(input logic [3:0] ini);
    cmd(ini, KIND_OTHER, 1'b0, 1'b1, V_CHK_UA);
    chk_bit(ua_pending[ini], 1'b1);
    cmd(ini, KIND_REQ_SENSE, 1'b0, 1'b1, V_SENSE_UA);
    chk_bit(ua_pending[ini], 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_attention;
    chk_bit(ua_pending[0], 1'b1);
    cmd(4'h0, KIND_INQUIRY, 1'b0, 1'b1, V_EXECUTE);
    chk_bit(ua_pending[0], 1'b1);
    ua_clear(4'h0);
    cmd(4'h2, KIND_REQ_SENSE, 1'b0, 1'b1, V_SENSE_UA);
    chk_bit(ua_pending[2], 1'b0);
  endtask

  // download by initiator 2 spares it, parameter change by 0 reaches it
  task automatic t_events;
    ua_ucode_evt = 1'b1;
    ua_src_init = 4'h2;
    @(negedge clk);
    ua_ucode_evt = 1'b0;
    repeat (2) @(negedge clk);
    chk_bit(ua_pending[2], 1'b0);
    chk_bit(ua_pending[0], 1'b1);
    ua_param_evt = 1'b1;
    ua_src_init = 4'h0;
    @(negedge clk);
    ua_param_evt = 1'b0;
    repeat (2) @(negedge clk);
    chk_bit(ua_pending[2], 1'b1);
    ua_clear(4'h0);
    ua_clear(4'h2);
  endtask

  task automatic t_overlap;
    cmd(4'h0, KIND_OTHER, 1'b0, 1'b1, V_EXECUTE);
    cmd(4'h0, KIND_OTHER, 1'b0, 1'b1, V_CHK_OVERLAP);
    chk_bit(term_valid, 1'b1);
    cmd(4'h0, KIND_OTHER, 1'b0, 1'b1, V_EXECUTE);
  endtask

  // initiator 0 stays active; initiator 2 queues, then dequeue is blocked
  task automatic t_queue;
    cmd(4'h2, KIND_INQUIRY, 1'b0, 1'b1, V_EXECUTE);
    cmd(4'h2, KIND_OTHER, 1'b0, 1'b0, V_BUSY);
    cmd(4'h2, KIND_OTHER, 1'b0, 1'b1, V_QUEUE);
    qslot = resp_slot;
    chk_num({1'b0, resp_slot}, 4'h1);
    deferred_error = 1'b1;
    deq_valid = 1'b1;
    deq_slot = qslot;
    @(negedge clk);
    deq_valid = 1'b0;
    deq_slot = ~qslot;
    chk_bit(deq_done, 1'b1);
    chk_bit(deq_blocked, 1'b1);
    deferred_error = 1'b0;
  endtask

  task automatic t_blocking;
    startup_format_active = 1'b1;
    cmd_lun_ok = 1'b0;
    cmd(4'h2, KIND_OTHER, 1'b0, 1'b1, V_CHK_LUN);
    cmd_lun_ok = 1'b1;
    cmd(4'h2, KIND_OTHER, 1'b0, 1'b1, V_CHK_NREADY);
    chk_bit(sense_pending[2], 1'b1);
    startup_format_active = 1'b0;
    cmd_concurrent_ok = 1'b1;
    cmd(4'h2, KIND_OTHER, 1'b0, 1'b1, V_EXECUTE);
    chk_bit(sense_pending[2], 1'b0);
    cmd_concurrent_ok = 1'b0;
    cmd(4'h0, KIND_OTHER, 1'b1, 1'b1, V_CHK_OVERLAP);
  endtask

  // a waiting format stalls others; clearing that queue warns its owner
  task automatic t_format;
    tagged_queue_disable = 1'b1;
    cmd(4'h0, KIND_FORMAT, 1'b0, 1'b1, V_QUEUE);
    cmd(4'h4, KIND_INQUIRY, 1'b0, 1'b1, V_BUSY);
    tagged_queue_disable = 1'b0;
    cmd(4'h4, KIND_INQUIRY, 1'b0, 1'b1, V_QFULL);
    clear_queue_evt = 1'b1;
    ua_src_init = 4'h2;
    @(negedge clk);
    clear_queue_evt = 1'b0;
    chk_bit(ua_pending[0], 1'b1);
    cmd(4'h0, KIND_OTHER, 1'b0, 1'b1, V_CHK_UA);
    cmd_concurrent_ok = 1'b1;
    cmd(4'h0, KIND_OTHER, 1'b0, 1'b1, V_EXECUTE);
    cmd_concurrent_ok = 1'b0;
    chk_bit(ua_pending[0], 1'b0);
    chk_bit(sense_pending[0], 1'b0);
    sense_set = 1'b1;
    sense_set_init = 4'h2;
    @(negedge clk);
    sense_set = 1'b0;
    cmd(4'h2, KIND_REQ_SENSE, 1'b0, 1'b1, V_EXECUTE);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // main sequence; every bench-driven input starts low except cmd_lun_ok and reset
  initial begin
    {cmd_linked, cmd_concurrent_ok, cmd_bus_error, startup_format_active,
     deferred_error, reservation_conflict, opcode_invalid, cdb_invalid,
     tagged_queue_disable, queue_error_policy, sense_set, sense_set_init,
     deq_valid, deq_slot, done_valid, done_slot, ua_reset_evt, ua_xcvr_evt,
     ua_threshold_evt, ua_param_evt, ua_ucode_evt, ua_src_init, ua_preempt_evt,
     ua_victim_init, clear_queue_evt, ca_clear_evt} = '0;
    cmd_lun_ok = 1'b1;
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    t_attention();
    t_events();
    t_overlap();
    t_queue();
    t_blocking();
    t_format();
    test_done();
  end
endmodule
